// ===== common/sec_eeprom_regs.svh
// Functional notes
// - array_layout_select high gives 128x16 words, low gives 256x8 bytes.
// - floating array_layout_select reads high, selecting the 16-bit organization.
// - serial output driven only during a read, released otherwise.
// - instruction is 13 bits in byte mode, 12 bits in word mode.
// - seven opcodes decoded; unlock, lock and bulk erase carry zero address.
// - only READ shifts data out on the serial output.
// - after READ and address, addressed word loads into output shift register.
// - a dummy zero precedes the first read data bit.
// - data fields are 8 bits in byte mode, 16 bits in word mode.
// - PROGRAM erases then rewrites the word, ready low for whole cycle.
// - ERASE sets addressed word to all ones, ready low meanwhile.
// - WRITE only clears erased bits; host erases before writing.
// - program, erase, write, bulk erase need unlock; reads never gated.
`ifndef SEC_EEPROM_REGS_SVH
`define SEC_EEPROM_REGS_SVH

`define SEC_CLK_KHZ 20000
`define SEC_PROG_TIME_US 30000
`define SEC_ERASE_TIME_US 15000
`define SEC_WRITE_TIME_US 15000

`define SEC_INSTR_LEN_B 13
`define SEC_INSTR_LEN_W 12
`define SEC_DATA_BITS_B 8
`define SEC_DATA_BITS_W 16

`define SEC_OPC_READ 4'h8
`define SEC_OPC_PROG_LO 3'h4
`define SEC_OPC_ERASE 4'he
`define SEC_OPC_WRITE 4'h6
`define SEC_OPC_UNLOCK 4'h3
`define SEC_OPC_LOCK 4'h0
`define SEC_OPC_BULK 4'h2

`define SEC_ERASED_BYTE 8'hff
`define SEC_LAYOUT_RESET 1'b1

`endif

// ===== common/sec_pkg.sv
package sec_pkg;

    typedef enum logic [2:0] {
        SEC_IDLE  = 3'h0,
        SEC_CMD   = 3'h1,
        SEC_RDATA = 3'h2,
        SEC_WDATA = 3'h3,
        SEC_BUSY  = 3'h4,
        SEC_DONE  = 3'h5
    } sec_state_t;

    typedef enum logic [1:0] {
        SEC_OP_PROG  = 2'h0,
        SEC_OP_ERASE = 2'h1,
        SEC_OP_WRITE = 2'h2,
        SEC_OP_BULK  = 2'h3
    } sec_op_t;

    typedef struct packed {
        logic cs;
        logic sclk;
        logic din;
        logic layout;
    } sec_pins_t;

endpackage

// ===== verilog/sec_eeprom.sv
`timescale 1ns/100ps
`default_nettype none
`include "sec_eeprom_regs.svh"

module sec_eeprom #(
    parameter int PROG_CYC = `SEC_PROG_TIME_US * (`SEC_CLK_KHZ / 1000),
    parameter int ERASE_CYC = `SEC_ERASE_TIME_US * (`SEC_CLK_KHZ / 1000),
    parameter int WRITE_CYC = `SEC_WRITE_TIME_US * (`SEC_CLK_KHZ / 1000)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chipSelectPin,
    input wire logic serialClkPin,
    input wire logic serial_in_pin,
    input wire logic array_layout_select,
    output logic serialOutPin,
    output logic serialOutEn,
    output logic readyStatusOut
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    sec_pkg::sec_pins_t raw, s1Q, s2Q, s3Q, fQ, fD;
    localparam sec_pkg::sec_pins_t PinsReset = '{cs: 1'b0, sclk: 1'b0, din: 1'b0,
        layout: `SEC_LAYOUT_RESET};

    assign raw = '{cs: chipSelectPin, sclk: serialClkPin, din: serial_in_pin,
        layout: array_layout_select};

    // a change counts only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_filt
            assign fD[gi] = (s2Q[gi] == s3Q[gi]) ? s2Q[gi] : fQ[gi];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // layout defaults high, as the pin pull-up would
            s1Q <= PinsReset;
            s2Q <= PinsReset;
            s3Q <= PinsReset;
            fQ <= PinsReset;
        end else begin
            s1Q <= raw;
            s2Q <= s1Q;
            s3Q <= s2Q;
            fQ <= fD;
        end
    end

    logic rise;
    assign rise = fD.sclk & ~fQ.sclk;

    // ----------------------------------------
    // command engine
    // ----------------------------------------
    sec_pkg::sec_state_t stQ, stD;
    sec_pkg::sec_op_t opQ, opD;
    logic [4:0] cntQ, cntD;
    logic [10:0] srQ, srD;
    logic [15:0] dsrQ, dsrD;
    logic [16:0] osrQ, osrD;
    logic [7:0] addrQ, addrD;
    logic [19:0] busyQ, busyD;
    logic wideQ, wideD, enQ, enD;
    logic memGo;
    logic [11:0] full;
    logic [3:0] opc;
    logic [7:0] cmdAddr;
    logic [15:0] wdata, rword;
    logic [4:0] cmdLast, dataLast;

    logic [7:0] mem [256];

    assign full = {srQ, fD.din};
    // word mode carries 7 address bits, byte mode 8
    assign opc = wideQ ? full[10:7] : full[11:8];
    assign cmdAddr = wideQ ? {1'b0, full[6:0]} : full[7:0];
    assign cmdLast = wideQ ? 5'(`SEC_INSTR_LEN_W - 2) : 5'(`SEC_INSTR_LEN_B - 2);
    assign dataLast = wideQ ? 5'(`SEC_DATA_BITS_W - 1) : 5'(`SEC_DATA_BITS_B - 1);
    assign wdata = {dsrQ[14:0], fD.din};
    assign rword = wideQ ? {mem[{cmdAddr[6:0], 1'b0}], mem[{cmdAddr[6:0], 1'b1}]}
                         : {8'h00, mem[cmdAddr]};

    always_comb begin
        stD = stQ;
        opD = opQ;
        cntD = cntQ;
        srD = srQ;
        dsrD = dsrQ;
        osrD = osrQ;
        addrD = addrQ;
        busyD = busyQ;
        wideD = wideQ;
        enD = enQ;
        memGo = 1'b0;
        case (stQ)
            sec_pkg::SEC_IDLE: begin
                if (fD.cs && rise && fD.din) begin
                    stD = sec_pkg::SEC_CMD;
                    cntD = 5'h00;
                    wideD = fD.layout;
                end
            end
            sec_pkg::SEC_CMD: begin
                if (rise) begin
                    srD = full[10:0];
                    cntD = cntQ + 5'h01;
                    if (cntQ == cmdLast) begin
                        addrD = cmdAddr;
                        cntD = 5'h00;
                        stD = sec_pkg::SEC_DONE;
                        if (opc == `SEC_OPC_READ) begin
                            // reads ignore the lock state
                            stD = sec_pkg::SEC_RDATA;
                            osrD = wideQ ? {1'b0, rword}
                                         : {1'b0, rword[7:0], 8'h00};
                        end else if (opc[2:0] == `SEC_OPC_PROG_LO) begin
                            stD = sec_pkg::SEC_WDATA;
                            opD = sec_pkg::SEC_OP_PROG;
                        end else if (opc == `SEC_OPC_WRITE) begin
                            stD = sec_pkg::SEC_WDATA;
                            opD = sec_pkg::SEC_OP_WRITE;
                        end else if (opc == `SEC_OPC_ERASE && enQ) begin
                            stD = sec_pkg::SEC_BUSY;
                            opD = sec_pkg::SEC_OP_ERASE;
                            busyD = 20'(ERASE_CYC - 1);
                            memGo = 1'b1;
                        end else if (cmdAddr == 8'h00) begin
                            if (opc == `SEC_OPC_UNLOCK) begin
                                enD = 1'b1;
                            end else if (opc == `SEC_OPC_LOCK) begin
                                enD = 1'b0;
                            end else if (opc == `SEC_OPC_BULK && enQ) begin
                                stD = sec_pkg::SEC_BUSY;
                                opD = sec_pkg::SEC_OP_BULK;
                                busyD = 20'(ERASE_CYC - 1);
                                memGo = 1'b1;
                            end
                        end
                    end
                end
            end
            sec_pkg::SEC_RDATA: begin
                if (rise) begin
                    osrD = {osrQ[15:0], 1'b0};
                    cntD = cntQ + 5'h01;
                    if (cntQ == dataLast + 5'h01) begin
                        stD = sec_pkg::SEC_DONE;
                    end
                end
            end
            sec_pkg::SEC_WDATA: begin
                if (rise) begin
                    dsrD = wdata;
                    cntD = cntQ + 5'h01;
                    if (cntQ == dataLast) begin
                        stD = sec_pkg::SEC_DONE;
                        if (enQ) begin
                            stD = sec_pkg::SEC_BUSY;
                            memGo = 1'b1;
                            busyD = (opQ == sec_pkg::SEC_OP_PROG) ? 20'(PROG_CYC - 1)
                                                                 : 20'(WRITE_CYC - 1);
                        end
                    end
                end
            end
            sec_pkg::SEC_BUSY: begin
                // self-timed: a deselect does not cut the cycle short
                busyD = busyQ - 20'h00001;
                if (busyQ == 20'h00000) begin
                    stD = fD.cs ? sec_pkg::SEC_DONE : sec_pkg::SEC_IDLE;
                end
            end
            sec_pkg::SEC_DONE: begin
                stD = sec_pkg::SEC_DONE;
            end
            default: begin
                stD = sec_pkg::SEC_IDLE;
            end
        endcase
        if (!fD.cs && stQ != sec_pkg::SEC_BUSY) begin
            stD = sec_pkg::SEC_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stQ <= sec_pkg::SEC_IDLE;
            opQ <= sec_pkg::SEC_OP_PROG;
            cntQ <= 5'h00;
            srQ <= 11'h000;
            dsrQ <= 16'h0000;
            osrQ <= 17'h00000;
            addrQ <= 8'h00;
            busyQ <= 20'h00000;
            wideQ <= `SEC_LAYOUT_RESET;
            enQ <= 1'b0;
        end else begin
            stQ <= stD;
            opQ <= opD;
            cntQ <= cntD;
            srQ <= srD;
            dsrQ <= dsrD;
            osrQ <= osrD;
            addrQ <= addrD;
            busyQ <= busyD;
            wideQ <= wideD;
            enQ <= enD;
        end
    end

    // ----------------------------------------
    // array update
    // ----------------------------------------
    // whole update lands at cycle start; the busy count only models the wait
    sec_pkg::sec_op_t memOp;
    logic [7:0] memAddr;
    assign memOp = opD;
    assign memAddr = (stQ == sec_pkg::SEC_CMD) ? cmdAddr : addrQ;

    always_ff @(posedge clk) begin
        if (memGo) begin
            for (int i = 0; i < 256; i++) begin
                logic hit;
                logic [7:0] nb;
                hit = wideQ ? (i[7:1] == memAddr[6:0]) : (i[7:0] == memAddr);
                nb = (wideQ && !i[0]) ? wdata[15:8] : wdata[7:0];
                if (memOp == sec_pkg::SEC_OP_BULK) begin
                    mem[i] <= `SEC_ERASED_BYTE;
                end else if (hit) begin
                    case (memOp)
                        sec_pkg::SEC_OP_PROG: mem[i] <= nb;
                        sec_pkg::SEC_OP_ERASE: mem[i] <= `SEC_ERASED_BYTE;
                        sec_pkg::SEC_OP_WRITE: mem[i] <= mem[i] & nb;
                        default: mem[i] <= mem[i];
                    endcase
                end
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign serialOutEn = (stQ == sec_pkg::SEC_RDATA);
    assign serialOutPin = serialOutEn & osrQ[16];
    assign readyStatusOut = (stQ != sec_pkg::SEC_BUSY);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_readDecoded;
        stQ == sec_pkg::SEC_CMD && rise && cntQ == cmdLast && opc == `SEC_OPC_READ;
    endsequence

    sequence s_dummyShown;
        serialOutEn && !serialOutPin;
    endsequence

    property p_readDummy;
        s_readDecoded |=> s_dummyShown;
    endproperty
    a_readDummy: assert property (p_readDummy) else $error("no dummy zero");

    property p_outOnlyRead;
        serialOutEn |-> stQ == sec_pkg::SEC_RDATA && $past(stQ) != sec_pkg::SEC_BUSY;
    endproperty
    a_outOnlyRead: assert property (p_outOnlyRead) else $error("output outside read");

    property p_readyLow;
        $rose(stQ == sec_pkg::SEC_BUSY) |-> !readyStatusOut [*2];
    endproperty
    a_readyLow: assert property (p_readyLow) else $error("ready high while busy");

    property p_lockGate;
        $rose(stQ == sec_pkg::SEC_BUSY) |-> $past(enQ);
    endproperty
    a_lockGate: assert property (p_lockGate) else $error("busy while locked");

    property p_deselect;
        !fD.cs && stQ != sec_pkg::SEC_BUSY |=> stQ == sec_pkg::SEC_IDLE;
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselect ignored");

    property p_cmdLen;
        stQ == sec_pkg::SEC_CMD && rise && cntQ == cmdLast |=> stQ != sec_pkg::SEC_CMD;
    endproperty
    a_cmdLen: assert property (p_cmdLen) else $error("instruction length wrong");

    property p_layout;
        stQ == sec_pkg::SEC_IDLE && fD.cs && rise && fD.din |=> wideQ == $past(fD.layout);
    endproperty
    a_layout: assert property (p_layout) else $error("layout not taken");

    property p_erase;
        $rose(stQ == sec_pkg::SEC_BUSY) && opQ == sec_pkg::SEC_OP_ERASE && !wideQ
            |-> mem[addrQ] == `SEC_ERASED_BYTE;
    endproperty
    a_erase: assert property (p_erase) else $error("erase left zeros");

    property p_readLen;
        stQ == sec_pkg::SEC_RDATA && rise && cntQ == dataLast + 5'h01 |=> !serialOutEn;
    endproperty
    a_readLen: assert property (p_readLen) else $error("read ran long");

endmodule

`default_nettype wire

// ===== tb/sec_host.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// host side of the serial link
// ----------------------------------------
module sec_host (
    input wire logic clk,
    output logic chipSelect,
    output logic serialClk,
    output logic serialIn,
    output logic readPhase,
    input wire logic serialOut,
    input wire logic serialOutEn
);
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // serial clock 400 ns, stands low between frames
    task automatic frame(input logic [31:0] bits, input int n, input int nRd,
            output logic [15:0] rd, output logic dummy, output logic enOk);
        rd = '0;
        dummy = 1'b1;
        enOk = 1'b1;
        chipSelect = 1'b1;
        tick(4);
        for (int i = n - 1; i >= 0; i--) begin
            serialIn = bits[i];
            tick(4);
            serialClk = 1'b1;
            if (i == 0 && nRd > 0) begin
                readPhase = 1'b1;
            end
            tick(4);
            serialClk = 1'b0;
        end
        for (int i = 0; i <= nRd && nRd > 0; i++) begin
            serialIn = ~serialIn;
            tick(4);
            if (i == 0) begin
                dummy = serialOut;
            end else begin
                rd = {rd[14:0], serialOut};
            end
            enOk &= serialOutEn;
            serialClk = 1'b1;
            tick(4);
            serialClk = 1'b0;
        end
        tick(2);
        chipSelect = 1'b0;
        serialIn = ~serialIn;
        tick(6);
        readPhase = 1'b0;
    endtask

    initial begin
        chipSelect = 1'b0;
        serialClk = 1'b0;
        serialIn = 1'b0;
        readPhase = 1'b0;
    end
endmodule

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    localparam int PROG_N = 20;
    localparam int ERASE_N = 12;
    localparam int WRITE_N = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic layoutSel = 1'b0;
    logic chipSelect, serialClk, serialIn, readPhase;
    logic serialOut, serialOutEn, ready;
    logic [15:0] lowCnt = '0;
    logic [15:0] lastLow = '0;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;

    sec_eeprom #(.PROG_CYC(PROG_N), .ERASE_CYC(ERASE_N), .WRITE_CYC(WRITE_N)) sec_eeprom_i (
        .clk(clk), .rst_n(rst_n), .chipSelectPin(chipSelect), .serialClkPin(serialClk),
        .serial_in_pin(serialIn), .array_layout_select(layoutSel),
        .serialOutPin(serialOut), .serialOutEn(serialOutEn), .readyStatusOut(ready));
    sec_host sec_host_i (
        .clk(clk), .chipSelect(chipSelect), .serialClk(serialClk), .serialIn(serialIn),
        .readPhase(readPhase), .serialOut(serialOut), .serialOutEn(serialOutEn));

    always #25 clk = ~clk;

    // ----------------------------------------
    // monitors
    // ----------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (ready === 1'b0) begin
            lowCnt <= lowCnt + 16'h1;
        end else begin
            if (lowCnt != 0) lastLow <= lowCnt;
            lowCnt <= '0;
        end
        if (rst_n === 1'b1 && serialOutEn !== 1'b0 && !readPhase) begin
            errors++;
            $display("unexpected at %0t: output driven outside a read", $time);
        end
        if (cycles == 30000) begin
            errors++;
            complete_run();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic run(input logic [3:0] opc, input logic [7:0] addr, input logic [15:0] data,
            input int nData, input int nRd, output logic [15:0] rd);
        int aw;
        logic [31:0] bits;
        logic dm, en;
        aw = layoutSel ? 7 : 8;
        bits = {27'h0, 1'b1, opc};
        bits = (bits << aw) | {24'h0, addr};
        bits = (bits << nData) | {16'h0, data};
        lastLow = '0;
        sec_host_i.frame(bits, 5 + aw + nData, nRd, rd, dm, en);
        if (nRd > 0) begin
            check({15'h0, dm}, 16'h0);
            check({15'h0, en}, 16'h1);
        end
    endtask

    task automatic cmd(input logic [3:0] opc, input logic [7:0] addr, input logic [15:0] data);
        logic [15:0] rd;
        run(opc, addr, data, (opc == 4'he || opc[3:2] == 2'b00) ? 0 : (layoutSel ? 16 : 8), 0, rd);
    endtask

    task automatic read_expect(input logic [7:0] addr, input logic [15:0] exp);
        logic [15:0] rd;
        run(4'h8, addr, 16'h0, 0, layoutSel ? 16 : 8, rd);
        check(rd, exp);
    endtask

    task automatic wait_busy(input int n);
        for (int i = 0; i < 300 && lastLow == 0; i++) @(posedge clk);
        #1;
        check(lastLow, 16'(n));
    endtask

    task automatic no_busy();
        repeat (60) @(posedge clk);
        #1;
        check(lastLow, 16'h0);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_locked_program();
        check({15'h0, serialOutEn}, 16'h0);
        check({15'h0, ready}, 16'h1);
        cmd(4'h4, 8'h5a, 16'ha5);
        no_busy();
    endtask

    task automatic t_program();
        cmd(4'h3, 8'h00, 16'h0);
        cmd(4'hc, 8'h5a, 16'ha5);
        wait_busy(PROG_N);
        read_expect(8'h5a, 16'ha5);
        cmd(4'h4, 8'hff, 16'h3c);
        wait_busy(PROG_N);
        read_expect(8'hff, 16'h3c);
    endtask

    task automatic t_erase_write();
        cmd(4'he, 8'h10, 16'h0);
        wait_busy(ERASE_N);
        read_expect(8'h10, 16'hff);
        cmd(4'h6, 8'h10, 16'h3c);
        wait_busy(WRITE_N);
        cmd(4'h6, 8'h10, 16'hf0);
        wait_busy(WRITE_N);
        read_expect(8'h10, 16'h30);
    endtask

    task automatic t_word_mode();
        layoutSel = 1'b1;
        cmd(4'h4, 8'h2d, 16'hbeef);
        wait_busy(PROG_N);
        read_expect(8'h2d, 16'hbeef);
        layoutSel = 1'b0;
        read_expect(8'h5a, 16'hbe);
    endtask

    task automatic t_abort();
        logic [15:0] rd;
        logic dm, en;
        sec_host_i.frame(32'hc5, 8, 0, rd, dm, en);
        read_expect(8'h5b, 16'hef);
    endtask

    task automatic t_bulk_lock();
        cmd(4'h2, 8'h00, 16'h0);
        wait_busy(ERASE_N);
        read_expect(8'h5a, 16'hff);
        cmd(4'h0, 8'h00, 16'h0);
        cmd(4'hc, 8'h5a, 16'h12);
        no_busy();
        read_expect(8'h5a, 16'hff);
    endtask

    task automatic complete_run();
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        sec_host_i.tick(4);
        t_locked_program();
        t_program();
        t_erase_write();
        t_word_mode();
        t_abort();
        t_bulk_lock();
        complete_run();
    end
endmodule

`default_nettype wire
